// ---- pmc_pkg.sv ----
package pmc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  CMD_ADDR    = 8'h04;
  localparam logic [7:0]  STATUS_ADDR = 8'h08;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_SLOW_BIT    = 0;
  localparam int CTRL_DIV_LSB     = 1;
  localparam int CTRL_OSC_IRQ_BIT = 3;
  localparam int CMD_WAIT_BIT   = 0;
  localparam int CMD_HALT_BIT   = 1;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam logic [1:0]  MASK_ALL_ENABLE = 2'b10;
  localparam int          WAKE_SRC_W      = 7;
  localparam logic [31:0] SHORT_DELAY     = 32'h0000_0100;
  localparam logic [31:0] LONG_DELAY      = 32'h0000_1000;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Power modes, one-hot
  typedef enum logic [5:0] {
    MODE_RUN       = 6'b00_0001,
    MODE_WAIT      = 6'b00_0010,
    MODE_ACT_HALT  = 6'b00_0100,
    MODE_HALT      = 6'b00_1000,
    MODE_SETTLE    = 6'b01_0000,
    MODE_WDG_RESET = 6'b10_0000
  } mode_t;

endpackage : pmc_pkg

// ---- power_mode_controller.sv ----
// Functional notes
// - After reset the block runs in Run mode from the undivided master clock.
// - Slow select plus two-bit field divides master clock by 2, 4, 8 or 16.
// - Wait entered while slow is active keeps the divided clock on peripherals.
// - Wait instruction stops the CPU clock; peripherals keep running.
// - Entering Wait forces the interrupt mask level to binary 10.
// - Wait ends only on interrupt or reset; CPU then takes the vector.
// - CPU core stacks the condition codes before servicing; mask restored on pop.
// - Halt instruction enters Halt if oscillator irq enable is 0, else Active Halt.
// - Active Halt exits with no delay on time base or permitted wake irq; reset exit goes through settle.
// - Reset exit from Active Halt applies settle delay before vector fetch.
// - Entering either halt forces mask to 10; pending wake exits at once.
// - In Active Halt only oscillator and time-base counter keep running.
// - With oscillator irq enable set, Active Halt never causes a watchdog reset.
// - Settle delay length, 256 or 4096 cycles, comes from a non-volatile option.
// - Leaving Halt restarts oscillator at once; CPU resumes after settle delay.
// - In Halt the oscillator stops and all internal clocks stop.
// - Watchdog option decides whether halt with watchdog enabled resets the device.
// - Only time base, four external groups, serial peripheral and reset wake halt.
`timescale 1ns/1ns

module power_mode_controller #(
  parameter int unsigned SHORT_CYCLES = 256,
  parameter int unsigned LONG_CYCLES  = 4096
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU core side
  input  wire logic        wait_for_interrupt_op,
  input  wire logic        halt_op,
  input  wire logic [1:0]  cond_mask_level,
  output logic             cond_mask_force,
  output logic [1:0]       cond_mask_value,
  output logic             cpu_run,
  output logic             vector_fetch,
  // Wake sources: [0] time base, [4:1] external groups, [5] serial, [6] other
  input  wire logic [6:0]  irq_req,
  input  wire logic        watchdog_active,
  input  wire logic        watchdog_stop_option,
  input  wire logic        long_delay_option,
  input  wire logic        ext_reset_req,
  // Clock controller side
  output logic             osc_enable,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             timebase_clk_en,
  output logic             watchdog_reset
);

  // ----------------------------------------------------------------------
  // Control register and state
  // ----------------------------------------------------------------------
  logic [3:0]         ctrl_q;
  pmc_pkg::mode_t     mode_q;
  logic [12:0]        settle_cnt_q;
  logic               settle_irq_q;
  logic [3:0]         div_cnt_q;
  logic               slow_q;
  logic               wake_any;
  logic               halt_wake;
  logic               tick;
  logic [3:0]         div_mask;
  logic [12:0]        settle_len;

  wire slow_mode_select       = ctrl_q[pmc_pkg::CTRL_SLOW_BIT];
  wire [1:0] slow_divider_select = ctrl_q[pmc_pkg::CTRL_DIV_LSB +: 2];
  wire oscillator_irq_enable  = ctrl_q[pmc_pkg::CTRL_OSC_IRQ_BIT];

  // Any enabled interrupt wakes Wait; only the permitted set wakes halts
  assign wake_any  = |irq_req;
  assign halt_wake = |irq_req[5:0];
  assign settle_len = long_delay_option ? 13'(LONG_CYCLES) : 13'(SHORT_CYCLES);

  // ----------------------------------------------------------------------
  // Slow clock divider
  // ----------------------------------------------------------------------
  // Divide by 2, 4, 8 or 16 selects how many counter bits must be all ones
  always_comb begin
    unique case (slow_divider_select)
      2'd0:    div_mask = 4'b0001;
      2'd1:    div_mask = 4'b0011;
      2'd2:    div_mask = 4'b0111;
      default: div_mask = 4'b1111;
    endcase
  end

  // Tick is one master-clock enable pulse per slow period
  assign tick = !slow_q || ((div_cnt_q & div_mask) == div_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 4'h0;
      slow_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
      // Slow select only takes effect on a divided-period boundary
      if (tick) begin
        slow_q <= slow_mode_select;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_fire;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pmc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == pmc_pkg::CTRL_ADDR || awaddr_q == pmc_pkg::CMD_ADDR)
                        ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software commands share the instruction inputs as extra request sources
  wire sw_wait = wr_fire && awaddr_q == pmc_pkg::CMD_ADDR && wstrb_q[0]
                 && wdata_q[pmc_pkg::CMD_WAIT_BIT];
  wire sw_halt = wr_fire && awaddr_q == pmc_pkg::CMD_ADDR && wstrb_q[0]
                 && wdata_q[pmc_pkg::CMD_HALT_BIT];

  // Control register: slow select, divider field, oscillator irq enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= pmc_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_q == pmc_pkg::CTRL_ADDR && wstrb_q[0]) begin
      ctrl_q <= wdata_q[3:0];
    end
  end

  // Read channel: one word per request, unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pmc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pmc_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          pmc_pkg::CTRL_ADDR:   s_axi_rdata <= {28'h000_0000, ctrl_q};
          pmc_pkg::CMD_ADDR:    s_axi_rdata <= 32'h0000_0000;
          pmc_pkg::STATUS_ADDR: s_axi_rdata <= {12'h000, settle_cnt_q, slow_q, mode_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pmc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------------
  wire do_wait = wait_for_interrupt_op || sw_wait;
  wire do_halt = halt_op || sw_halt;

  always_ff @(posedge aclk) begin
    if (!aresetn || ext_reset_req && mode_q != pmc_pkg::MODE_ACT_HALT
                                  && mode_q != pmc_pkg::MODE_HALT) begin
      mode_q       <= pmc_pkg::MODE_RUN;
      settle_cnt_q <= 13'h0000;
      settle_irq_q <= 1'b0;
    end else begin
      unique case (mode_q)
        pmc_pkg::MODE_RUN: begin
          if (do_halt) begin
            if (oscillator_irq_enable) begin
              mode_q <= pmc_pkg::MODE_ACT_HALT;
            end else if (watchdog_active && !watchdog_stop_option) begin
              mode_q <= pmc_pkg::MODE_WDG_RESET;
            end else begin
              mode_q <= pmc_pkg::MODE_HALT;
            end
          end else if (do_wait) begin
            mode_q <= pmc_pkg::MODE_WAIT;
          end
        end
        pmc_pkg::MODE_WAIT: begin
          if (wake_any) begin
            mode_q <= pmc_pkg::MODE_RUN;
          end
        end
        pmc_pkg::MODE_ACT_HALT: begin
          if (ext_reset_req) begin
            mode_q       <= pmc_pkg::MODE_SETTLE;
            settle_cnt_q <= settle_len;
            settle_irq_q <= 1'b0;
          end else if (halt_wake) begin
            mode_q <= pmc_pkg::MODE_RUN;
          end
        end
        pmc_pkg::MODE_HALT: begin
          if (ext_reset_req || halt_wake) begin
            mode_q       <= pmc_pkg::MODE_SETTLE;
            settle_cnt_q <= settle_len;
            settle_irq_q <= !ext_reset_req;
          end
        end
        pmc_pkg::MODE_SETTLE: begin
          // Count CPU cycles so the delay scales with the slow divider
          if (tick) begin
            settle_cnt_q <= settle_cnt_q - 13'h0001;
            if (settle_cnt_q == 13'h0001) begin
              mode_q <= pmc_pkg::MODE_RUN;
            end
          end
        end
        pmc_pkg::MODE_WDG_RESET: begin
          mode_q <= pmc_pkg::MODE_RUN;
        end
        default: mode_q <= pmc_pkg::MODE_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Clock gating and core handshakes, all registered
  // ----------------------------------------------------------------------
  // Gates follow the mode register and the divided tick, so they only
  // change on master clock edges and cannot chop a clock pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable      <= 1'b1;
      cpu_clk_en      <= 1'b1;
      periph_clk_en   <= 1'b1;
      timebase_clk_en <= 1'b1;
      cond_mask_force <= 1'b0;
      cond_mask_value <= pmc_pkg::MASK_ALL_ENABLE;
      cpu_run         <= 1'b1;
      vector_fetch    <= 1'b0;
      watchdog_reset  <= 1'b0;
    end else begin
      osc_enable      <= mode_q != pmc_pkg::MODE_HALT;
      cpu_clk_en      <= tick && mode_q == pmc_pkg::MODE_RUN;
      periph_clk_en   <= tick && (mode_q == pmc_pkg::MODE_RUN
                                  || mode_q == pmc_pkg::MODE_WAIT);
      timebase_clk_en <= mode_q != pmc_pkg::MODE_HALT
                         && mode_q != pmc_pkg::MODE_SETTLE;
      // Mask forced to 10 for one cycle on each low-power entry
      cond_mask_force <= mode_q == pmc_pkg::MODE_RUN && !ext_reset_req
                         && (do_wait || do_halt);
      cond_mask_value <= pmc_pkg::MASK_ALL_ENABLE;
      cpu_run         <= mode_q == pmc_pkg::MODE_RUN;
      // Pulse when the core may take the interrupt or reset vector
      vector_fetch    <= (mode_q == pmc_pkg::MODE_WAIT && wake_any)
                      || (mode_q == pmc_pkg::MODE_ACT_HALT && halt_wake && !ext_reset_req)
                      || (mode_q == pmc_pkg::MODE_SETTLE && tick
                          && settle_cnt_q == 13'h0001);
      watchdog_reset  <= mode_q == pmc_pkg::MODE_WDG_RESET;
    end
  end

endmodule : power_mode_controller

// ---- pmc_props.sv ----
`timescale 1ns/1ns
module pmc_props #(
  parameter int unsigned SHORT_CYCLES = 256,
  parameter int unsigned LONG_CYCLES  = 4096
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       wait_for_interrupt_op,
  input wire logic       halt_op,
  input wire logic       cpu_run,
  input wire logic       cond_mask_force,
  input wire logic [1:0] cond_mask_value,
  input wire logic       vector_fetch,
  input wire logic [6:0] irq_req,
  input wire logic       watchdog_active,
  input wire logic       watchdog_stop_option,
  input wire logic       ext_reset_req,
  input wire logic       osc_enable,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       timebase_clk_en,
  input wire logic       watchdog_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] up_q;
  wire         quiet  = irq_req[5:0] == 6'h00 && !ext_reset_req;
  wire         run_ok = cpu_run && !ext_reset_req && irq_req == 7'h00;
  wire         no_wdg = watchdog_stop_option || !watchdog_active;
  // ----------------------------------------------------------------------
  // Cycles since the oscillator came up; starts full so early wakes pass
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
    if (!aresetn) up_q <= 16'hFFFF;
    else if (!osc_enable) up_q <= 16'h0000;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
  // ----------------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------------
  property p_reset_run; $rose(aresetn) |-> cpu_run && osc_enable; endproperty
  a_reset_run: assert property (p_reset_run) else $error("not running after reset");
  property p_wait_stop; wait_for_interrupt_op && !halt_op && run_ok |-> ##2 !cpu_run && osc_enable; endproperty
  a_wait_stop: assert property (p_wait_stop) else $error("wait did not stop cpu");
  property p_wait_mask;
    wait_for_interrupt_op && !halt_op && run_ok |-> ##1 cond_mask_force && cond_mask_value == 2'b10;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("wait mask not forced");
  // Mask force shows one cycle after the op, the stopped core one cycle later
  property p_halt_in;
    halt_op && cpu_run && quiet && no_wdg |-> ##1 cond_mask_force ##1 !cpu_run;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt entry wrong");
  property p_osc_off; !osc_enable |-> !cpu_clk_en && !periph_clk_en && !timebase_clk_en; endproperty
  a_osc_off: assert property (p_osc_off) else $error("clock runs with oscillator off");
  property p_halt_hold; quiet ##1 (quiet && !osc_enable) |-> ##2 !osc_enable; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake");
  property p_wake; !osc_enable && !quiet |-> ##[1:2] osc_enable; endproperty
  a_wake: assert property (p_wake) else $error("oscillator not restarted");
  property p_settle; vector_fetch |-> up_q >= SHORT_CYCLES - 2; endproperty
  a_settle: assert property (p_settle) else $error("vector before settle delay");
  property p_wdg_opt; halt_op && cpu_run && watchdog_stop_option |-> ##1 !watchdog_reset [*3]; endproperty
  a_wdg_opt: assert property (p_wdg_opt) else $error("watchdog reset despite option");
  property p_vec_pulse; vector_fetch |=> !vector_fetch; endproperty
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector fetch not one pulse");
  c_wake: cover property (!osc_enable ##1 osc_enable);
  c_wdg: cover property (watchdog_reset);
  c_wait: cover property (wait_for_interrupt_op && cpu_run);
endmodule : pmc_props

bind power_mode_controller pmc_props #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES))
  i_props (.*);

// ---- cpu_core_model.sv ----
`timescale 1ns/1ns
module cpu_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go_wait,
  input  wire logic       go_halt,
  input  wire logic       cond_mask_force,
  input  wire logic [1:0] cond_mask_value,
  input  wire logic       cpu_run,
  input  wire logic       vector_fetch,
  output logic            wait_for_interrupt_op,
  output logic            halt_op,
  output logic [1:0]      cond_mask_level
);
  // A stopped core executes nothing, so ops only leave it while running
  always_ff @(posedge aclk) begin
    wait_for_interrupt_op <= aresetn && go_wait && cpu_run;
    halt_op               <= aresetn && go_halt && cpu_run && !go_wait;
  end
  // Mask level: forced loads win; a serviced vector lifts it to routine level
  always_ff @(posedge aclk)
    if (!aresetn) cond_mask_level <= 2'b11;
    else if (cond_mask_force) cond_mask_level <= cond_mask_value;
    else if (vector_fetch) cond_mask_level <= 2'b11;
endmodule : cpu_core_model

// ---- power_mode_controller_tb_top.sv ----
`timescale 1ns/1ns
module power_mode_controller_tb_top;
  localparam int unsigned SH = 6;
  localparam int unsigned LG = 12;
  localparam logic [1:0]  OK = pmc_pkg::RESP_OKAY;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, wait_for_interrupt_op, halt_op, cond_mask_force, cpu_run;
  logic        vector_fetch, watchdog_active, watchdog_stop_option, long_delay_option;
  logic        ext_reset_req, osc_enable, cpu_clk_en, periph_clk_en, timebase_clk_en;
  logic        watchdog_reset, go_wait, go_halt;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cond_mask_level, cond_mask_value;
  logic [6:0]  irq_req;
  logic [65:0] rx;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  int          errors = 0, n_tests = 0, cyc = 0, wdg = 0, n, c0, c1;

  power_mode_controller #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG)) i_dut (.*);
  cpu_core_model i_cpu (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (s_axi_awready) ap = 1'b0;
      if (s_axi_wready) wp = 1'b0;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back({m, r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic st(input logic [6:0] e);
    rd(pmc_pkg::STATUS_ADDR, {25'h000_0000, e}, 32'h0000_007F, OK);
  endtask : st
  task automatic op(input logic h, input int w);
    go_halt <= h;
    go_wait <= !h;
    @(posedge aclk);
    go_halt <= 1'b0;
    go_wait <= 1'b0;
    repeat (w) @(posedge aclk);
  endtask : op
  // Pulses of the cpu and peripheral enables over a 32 cycle window
  task automatic cnt;
    c0 = 0;
    c1 = 0;
    repeat (32) begin
      @(posedge aclk);
      c0 += cpu_clk_en;
      c1 += periph_clk_en;
    end
  endtask : cnt
  task automatic wv(output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (vector_fetch !== 1'b1);
  endtask : wv
  // ----------------------------------------------------------------------
  // Watcher: answers are matched against the oldest note; hang guard
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rx = rq.pop_front();
      chk("rdata", rx[33:0], {s_axi_rresp, s_axi_rdata & rx[65:34]});
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (watchdog_reset === 1'b1) wdg++;
    cyc++;
    if (cyc > 6000) begin
      errors++;
      results();
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {aresetn, go_wait, go_halt, watchdog_active, watchdog_stop_option} = 5'h00;
    {long_delay_option, ext_reset_req, irq_req, s_axi_awaddr, s_axi_araddr} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    void'($urandom(2486));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st({1'b0, pmc_pkg::MODE_RUN});
    rd(pmc_pkg::CTRL_ADDR, 32'h0000_0000, 32'h0000_000F, OK);
    rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF, pmc_pkg::RESP_SLVERR);
    wr(8'h0C, 32'h0000_0001, pmc_pkg::RESP_SLVERR);
    for (int d = 0; d < 4; d++) begin
      wr(pmc_pkg::CTRL_ADDR, 32'(d * 2 + 1), OK);
      rd(pmc_pkg::CTRL_ADDR, 32'(d * 2 + 1), 32'h0000_000F, OK);
      repeat (20) @(posedge aclk);
      cnt();
      chk("cpu_div", 34'(16 >> d), 34'(c0));
    end
    // Wait entered from divide-by-16 slow mode
    op(1'b0, 6);
    st({1'b1, pmc_pkg::MODE_WAIT});
    cnt();
    chk("cpu_wait", 34'h0, 34'(c0));
    chk("periph_wait", 34'h2, 34'(c1));
    chk("mask_wait", 34'h2, 34'(cond_mask_level));
    irq_req <= 7'h40;
    repeat (40) @(posedge aclk);
    st({1'b1, pmc_pkg::MODE_RUN});
    wr(pmc_pkg::CTRL_ADDR, 32'h0000_0000, OK);
    watchdog_active <= 1'b1;
    watchdog_stop_option <= 1'b1;
    // Halt, woken by a random wake source while a non-wake request stays up
    for (int o = 0; o < 2; o++) begin
      long_delay_option <= o[0];
      op(1'b1, 6);
      st({1'b0, pmc_pkg::MODE_HALT});
      chk("osc_halt", 34'h0, 34'(osc_enable));
      chk("mask_halt", 34'h2, 34'(cond_mask_level));
      irq_req <= 7'h40 | 7'(1 << $urandom_range(5, 1));
      wv(n);
      chk("settle", 34'h1, 34'(n >= (o ? LG : SH) && n <= (o ? LG : SH) + 6));
      irq_req <= 7'h40;
    end
    irq_req <= 7'h00;
    watchdog_stop_option <= 1'b0;
    wr(pmc_pkg::CTRL_ADDR, 32'h0000_0008, OK);
    op(1'b1, 6);
    st({1'b0, pmc_pkg::MODE_ACT_HALT});
    cnt();
    chk("act_clocks", 34'h0, 34'(c0 + c1));
    chk("act_osc_tb", 34'h3, 34'({osc_enable, timebase_clk_en}));
    irq_req <= 7'h01;
    wv(n);
    chk("act_irq_exit", 34'h1, 34'(n <= 4));
    irq_req <= 7'h00;
    // Software halt command enters Active Halt; reset exit waits for the settle delay
    wr(pmc_pkg::CMD_ADDR, 32'h0000_0002, OK);
    ext_reset_req <= 1'b1;
    @(posedge aclk);
    ext_reset_req <= 1'b0;
    wv(n);
    chk("act_reset_exit", 34'h1, 34'(n >= SH));
    irq_req <= 7'h04;
    op(1'b1, 0);
    wv(n);
    chk("pending_wake", 34'h1, 34'(n <= 6));
    irq_req <= 7'h00;
    chk("wdg_none", 34'h0, 34'(wdg));
    wr(pmc_pkg::CTRL_ADDR, 32'h0000_0000, OK);
    op(1'b1, 8);
    chk("wdg_fire", 34'h1, 34'(wdg));
    results();
  end
endmodule : power_mode_controller_tb_top
